// ---- hw/bdc_control.sv ----
// bdc_control.sv: background debug control: register bank, lockout,
// access pacing with cycle stealing, clock select and idle timeout.
// assumes: serial shifter front end outside drives the shift-in strobes;
// the processor bus offers free-cycle and access-complete indications.
`timescale 1ns/10ps
`default_nettype none
`include "bdc_defines.svh"
module bdc_control
	import bdc_pkg::*;
#(
	parameter int IDLE_LIMIT = `BDC_IDLE_LIMIT,
	parameter int STEAL_WAIT = 128
)
(
	input  wire logic        clk_sys,        // system clock
	input  wire logic        rst,            // synchronous reset
	input  wire logic        specialModeN,   // special mode, active low
	input  wire logic        singleChip,     // special single chip mode
	input  wire logic        periphMode,     // special peripheral mode
	input  wire logic        shadowLockBit,  // shadow byte bit 7
	input  wire logic        lockWrEn,       // write lockout-disable bit
	input  wire logic        lockWrData,     // new lockout-disable value
	input  wire logic        altClkTick,     // alternate bus clock enable
	input  wire logic        perClkTick,     // peripheral bus clock enable
	input  wire logic        perClkSlower,   // peripheral clock slower
	input  wire logic        hostFall,       // host falling edge on pin
	input  wire logic        cmdValid,       // instruction byte received
	input  wire logic [7:0]  cmdByte,        // received instruction
	input  wire logic        shiftDone,      // shift operation complete
	input  wire logic [15:0] shiftIn,        // shifted-in word
	input  wire logic        addrLoad,       // address word received
	input  wire logic        accReq,         // hardware memory access
	input  wire logic        accMulti,       // access needs many cycles
	input  wire logic        busFree,        // processor leaves bus free
	input  wire logic        accComplete,    // memory access finished
	input  wire logic        enterReq,       // breakpoint entry request
	input  wire logic        ccIn,           // capture condition codes
	input  wire logic [7:0]  ccValue,        // processor condition codes
	input  wire logic        regWr,          // register bank write
	input  wire logic        regRd,          // register bank read
	input  wire logic [15:0] regAddr,        // register bank address
	input  wire logic [7:0]  regWdata,       // register bank write data
	output logic      [7:0]  regRdata,       // register bank read data
	output logic             regHit,         // address hit in bank
	output logic             busOwn,         // debug holds internal buses
	output logic             cpuFreeze,      // processor clocks frozen
	output logic             debugMapped,    // debug ROM and regs mapped
	output logic             debugActive,    // background mode active
	output logic             serialEnable,   // serial reception allowed
	output logic             lockoutDisable, // lockout-disable bit
	output logic             resetVecBlock,  // block reset-vector code
	output logic             serialTick,     // debug serial clock enable
	output logic      [1:0]  resumeKind,     // requested resume kind
	output logic      [2:0]  targetReg       // requested target register
);
	logic [7:0]  instr_r;
	logic [7:0]  status_r;
	logic [15:0] shift_r;
	logic [15:0] addr_r;
	logic [7:0]  ccSave_r;
	logic [9:0]  idleCnt_r;
	logic [7:0]  stealCnt_r;
	bdc_acc_t    acc_r;
	bdc_acc_t    acc_nxt;
	logic        actPend_r;
	logic        actVal_r;
	logic        tagPend_r;
	logic        enterNow;
	logic        actDone;
	logic        tagDone;
	logic        actBusy;
	logic        tagBusy;
	logic        stWr;
	logic        mapAccess;
	logic        lockInit_r;
	logic        cmdTake;
	// ==========================================
	// decode of bank addresses
	function automatic logic inBank(input logic [15:0] a);
		inBank = (a >= `BDC_ADDR_INSTR) && (a <= `BDC_ADDR_CCSAVE);
	endfunction
	// ==========================================
	// debug serial clock select
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			serialTick <= 1'b0;
		else if (status_r[`BDC_ST_CLKSEL] || perClkSlower)
			serialTick <= perClkTick;
		else
			serialTick <= altClkTick;
	end
	// ==========================================
	// lockout-disable bit, loaded after every reset
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			lockoutDisable <= 1'b0;
			lockInit_r     <= 1'b1;
		end
		else if (lockInit_r)
		begin
			lockoutDisable <= shadowLockBit;
			lockInit_r     <= 1'b0;
		end
		else if (lockWrEn && !specialModeN)
			lockoutDisable <= lockWrData;
	end
	// reset vector blocked in special single chip with lockout
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			resetVecBlock <= 1'b0;
		else
			resetVecBlock <= !lockInit_r && !lockoutDisable && singleChip;
	end
	// ==========================================
	// entry into background mode
	assign enterNow = lockoutDisable && status_r[`BDC_ST_ENABLE] && !status_r[`BDC_ST_ACTIVE]
		&& !lockInit_r
		&& (enterReq || (cmdTake && cmdByte == `BDC_INSTR_BACKGROUND_REQUEST));
	// serial commands are ignored while tagging holds reception off
	assign cmdTake = cmdValid && serialEnable;
	assign stWr = regWr && mapAccess && regAddr == `BDC_ADDR_STATUS;
	// delayed effect of a written active bit
	bdc_delay_line #(.COUNT(`BDC_ACT_DELAY)) u_actDelay
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (1'b1),
		.start   (stWr && !instr_r[`BDC_BIT_HWFW]),
		.busy    (actBusy),
		.done    (actDone)
	);
	// tag enable takes hold later
	bdc_delay_line #(.COUNT(`BDC_TAG_DELAY)) u_tagDelay
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (1'b1),
		.start   (tagPend_r),
		.busy    (tagBusy),
		.done    (tagDone)
	);
	// ==========================================
	// status register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			status_r  <= `BDC_STATUS_RESET;
			actPend_r <= 1'b0;
			actVal_r  <= 1'b0;
			tagPend_r <= 1'b0;
		end
		else if (lockInit_r)
		begin
			status_r[`BDC_ST_ACTIVE] <= (singleChip || periphMode) && shadowLockBit;
			tagPend_r <= 1'b0;
		end
		else
		begin
			tagPend_r <= 1'b0;
			// delayed active write first, so a new write in the same cycle stays pending
			if (actDone && actPend_r)
			begin
				status_r[`BDC_ST_ACTIVE] <= actVal_r;
				actPend_r <= 1'b0;
			end
			if (stWr)
			begin
				status_r[7]   <= regWdata[7];
				status_r[5:3] <= regWdata[5:3];
				if (instr_r[`BDC_BIT_HWFW])
					status_r[`BDC_ST_CLKSEL] <= regWdata[`BDC_ST_CLKSEL];
				else
				begin
					actPend_r <= 1'b1;
					actVal_r  <= regWdata[`BDC_ST_ACTIVE] && lockoutDisable;
				end
				tagPend_r <= regWdata[`BDC_ST_TAG];
			end
			if (cmdTake && !cmdByte[`BDC_BIT_HWFW] && cmdByte[4:3] == BDC_RK_TAG)
			begin
				status_r[`BDC_ST_TAG] <= 1'b1;
				tagPend_r <= 1'b1;
			end
			if (cmdTake && !cmdByte[`BDC_BIT_HWFW] && cmdByte[4:3] == BDC_RK_STEP)
				status_r[`BDC_ST_STEP] <= 1'b1;
			if (shiftDone)
				status_r[`BDC_ST_VALID] <= 1'b1;
			else if (cmdValid)
				status_r[`BDC_ST_VALID] <= 1'b0;
			if (enterNow)
			begin
				status_r[`BDC_ST_ACTIVE] <= 1'b1;
				status_r[`BDC_ST_TAG]    <= 1'b0;
			end
			status_r[1:0] <= 2'b00;
		end
	end
	// ==========================================
	// instruction register with idle timeout
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			instr_r   <= `BDC_INSTR_RESET;
			idleCnt_r <= 10'h000;
		end
		else
		begin
			if (hostFall)
				idleCnt_r <= 10'h000;
			else if (serialTick && idleCnt_r != 10'(IDLE_LIMIT))
				idleCnt_r <= idleCnt_r + 10'h001;
			if (cmdValid && serialEnable)
				instr_r <= cmdByte;
			else if (regWr && mapAccess && regAddr == `BDC_ADDR_INSTR)
				instr_r <= regWdata;
			else if (!hostFall && serialTick && idleCnt_r == 10'(IDLE_LIMIT - 1))
				instr_r <= `BDC_INSTR_RESET;
		end
	end
	// ==========================================
	// shifter, address and saved condition codes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			shift_r  <= 16'h0000;
			addr_r   <= 16'h0000;
			ccSave_r <= 8'h00;
		end
		else
		begin
			if (shiftDone)
				shift_r <= shiftIn;
			else if (regWr && mapAccess && regAddr == `BDC_ADDR_SHIFT_HI)
				shift_r[15:8] <= regWdata;
			else if (regWr && mapAccess && regAddr == `BDC_ADDR_SHIFT_LO)
				shift_r[7:0] <= regWdata;
			if (addrLoad)
				addr_r <= shiftIn;
			if (enterNow && ccIn)
				ccSave_r <= ccValue;
			else if (regWr && mapAccess && regAddr == `BDC_ADDR_CCSAVE)
				ccSave_r <= regWdata;
		end
	end
	// ==========================================
	// memory access pacing and cycle stealing
	always_comb
	begin
		acc_nxt = acc_r;
		case (acc_r)
			BDC_IDLE:  if (accReq) acc_nxt = busFree ? BDC_STEAL : BDC_WAIT;
			BDC_WAIT:  if (busFree || (serialTick && stealCnt_r == 8'(STEAL_WAIT - 1))) acc_nxt = BDC_STEAL;
			BDC_STEAL: if (accComplete) acc_nxt = BDC_DONE;
			BDC_DONE:  acc_nxt = BDC_IDLE;
			default:   acc_nxt = BDC_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			acc_r      <= BDC_IDLE;
			stealCnt_r <= 8'h00;
			busOwn     <= 1'b0;
			cpuFreeze  <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			if (acc_r == BDC_WAIT && serialTick)
				stealCnt_r <= stealCnt_r + 8'h01;
			else if (acc_r != BDC_WAIT)
				stealCnt_r <= 8'h00;
			busOwn    <= (acc_nxt == BDC_STEAL);
			cpuFreeze <= (acc_nxt == BDC_STEAL) && (accMulti || !busFree);
		end
	end
	// ==========================================
	// mapping, read data and outputs
	assign mapAccess = lockoutDisable && inBank(regAddr)
		&& (status_r[`BDC_ST_ACTIVE] || (acc_r == BDC_STEAL && instr_r[`BDC_BIT_MAPSEL]
		&& instr_r[`BDC_BIT_HWFW]));
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			regRdata     <= 8'h00;
			regHit       <= 1'b0;
			debugMapped  <= 1'b0;
			debugActive  <= 1'b0;
			serialEnable <= 1'b1;
			resumeKind   <= 2'b00;
			targetReg    <= 3'b000;
		end
		else
		begin
			regHit <= regRd && mapAccess;
			case (regAddr)
				`BDC_ADDR_INSTR:    regRdata <= instr_r;
				`BDC_ADDR_STATUS:   regRdata <= {status_r[7:2], 2'b00};
				`BDC_ADDR_SHIFT_HI: regRdata <= shift_r[15:8];
				`BDC_ADDR_SHIFT_LO: regRdata <= shift_r[7:0];
				`BDC_ADDR_ADDR_HI:  regRdata <= addr_r[15:8];
				`BDC_ADDR_ADDR_LO:  regRdata <= addr_r[7:0];
				`BDC_ADDR_CCSAVE:   regRdata <= ccSave_r;
				default:            regRdata <= 8'h00;
			endcase
			debugMapped  <= lockoutDisable && status_r[`BDC_ST_ACTIVE];
			debugActive  <= lockoutDisable && status_r[`BDC_ST_ACTIVE];
			serialEnable <= !(status_r[`BDC_ST_TAG] && !tagBusy && !tagPend_r) || status_r[`BDC_ST_ACTIVE];
			resumeKind   <= instr_r[`BDC_BIT_HWFW] ? 2'b00 : instr_r[4:3];
			targetReg    <= instr_r[`BDC_BIT_HWFW] ? 3'b000 : instr_r[2:0];
		end
	end
endmodule
`default_nettype wire

// ---- hw/bdc_defines.svh ----
// bdc_defines.svh: offsets, field positions, reset values and timing counts
// of the background debug control block.
// assumes: included by its bare name from the control module, the checker and the bench.
// ==========================================
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH
`define BDC_ADDR_INSTR     16'hFF00
`define BDC_ADDR_STATUS    16'hFF01
`define BDC_ADDR_SHIFT_HI  16'hFF02
`define BDC_ADDR_SHIFT_LO  16'hFF03
`define BDC_ADDR_ADDR_HI   16'hFF04
`define BDC_ADDR_ADDR_LO   16'hFF05
`define BDC_ADDR_CCSAVE    16'hFF06
`define BDC_MAP_BASE_HI    8'hFF
`define BDC_INSTR_RESET    8'h00
`define BDC_STATUS_RESET   8'h00
`define BDC_INSTR_BACKGROUND_REQUEST    8'h90
`define BDC_BIT_HWFW       7
`define BDC_BIT_DATA       6
`define BDC_BIT_RW         5
`define BDC_BIT_BKREQ      4
`define BDC_BIT_WORD       3
`define BDC_BIT_MAPSEL     2
`define BDC_ST_ENABLE      7
`define BDC_ST_ACTIVE      6
`define BDC_ST_TAG         5
`define BDC_ST_VALID       4
`define BDC_ST_STEP        3
`define BDC_ST_CLKSEL      2
`define BDC_ST_WMASK_ALL   8'hB8
`define BDC_ACT_DELAY      4
`define BDC_TAG_DELAY      16
`define BDC_IDLE_LIMIT     512
`endif

// ---- hw/bdc_pkg.sv ----
// bdc_pkg.sv: types of the background debug control block.
// assumes: nothing beyond the defines header.
`default_nettype none
package bdc_pkg;
	typedef enum logic [3:0]
	{
		BDC_IDLE  = 4'b0001,
		BDC_WAIT  = 4'b0010,
		BDC_STEAL = 4'b0100,
		BDC_DONE  = 4'b1000
	} bdc_acc_t;
	typedef enum logic [1:0]
	{
		BDC_RK_NONE = 2'b00,
		BDC_RK_GO   = 2'b01,
		BDC_RK_STEP = 2'b10,
		BDC_RK_TAG  = 2'b11
	} bdc_resume_t;
endpackage
`default_nettype wire

// ---- hw/bdc_delay_line.sv ----
// bdc_delay_line.sv: counts a fixed number of enabled ticks after a start
// pulse, then pulses done for one cycle.
// assumes: single clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module bdc_delay_line
#(
	parameter int COUNT = 4
)
(
	input  wire logic clk_sys, // system clock
	input  wire logic rst,     // synchronous reset
	input  wire logic tick,    // count enable
	input  wire logic start,   // restart the delay
	output logic      busy,    // delay running
	output logic      done     // one-cycle end pulse
);
	logic [7:0] cnt_r;
	// ==========================================
	// counter
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt_r <= 8'h00;
			done  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
				cnt_r <= 8'(COUNT);
			else if (tick && cnt_r != 8'h00)
			begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01)
					done <= 1'b1;
			end
		end
	end
	assign busy = (cnt_r != 8'h00);
endmodule
`default_nettype wire

// ---- tb/bdc_host_model.sv ----
// bdc_host_model.sv: debug host that sends instruction bytes and keeps the pacing gaps.
// assumes: sendReq is a one-cycle pulse while busy is low; serialTick is the serial clock.
`timescale 1ns/10ps
`default_nettype none
module bdc_host_model
(
	input  wire logic       clk_sys,    // clock
	input  wire logic       rst,        // sync reset
	input  wire logic       serialTick, // serial clock enable
	input  wire logic       sendReq,    // send a byte
	input  wire logic [7:0] sendByte,   // byte to send
	output logic            busy,       // frame or gap running
	output logic            hostFall,   // pin falling edge
	output logic            cmdValid,   // byte strobe
	output logic      [7:0] cmdByte     // byte, scrambled off strobe
);
	logic [7:0] gap_r;
	// ==========
	// frame: edge, then byte strobe; byte scrambles between strobes
	always_ff @(posedge clk_sys)
	begin
		hostFall <= sendReq && !busy;
		cmdValid <= hostFall;
		cmdByte  <= hostFall ? sendByte : ~cmdByte;
		if (rst)
			cmdByte <= 8'h00;
	end
	// gap after each byte, counted in serial clocks
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			busy  <= 1'b0;
			gap_r <= 8'h00;
		end
		else if (sendReq)
		begin
			busy  <= 1'b1;
			gap_r <= 8'hFF;
		end
		else if (cmdValid)
			gap_r <= (cmdByte[7:5] == 3'h2) ? 8'h20 : (!cmdByte[7] && cmdByte[4:3] != 2'h0) ? 8'h40 : 8'h02;
		else if (gap_r == 8'h00)
			busy <= 1'b0;
		else if (serialTick)
			gap_r <= gap_r - 8'h01;
	end
endmodule
`default_nettype wire

// ---- tb/bdc_control_chk.sv ----
// bdc_control_chk.sv: port assertions on the debug control block.
// assumes: bound to bdc_control; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "bdc_defines.svh"
module bdc_control_chk
(
	input wire logic        clk_sys,        // clock
	input wire logic        rst,            // reset
	input wire logic        specialModeN,   // special mode
	input wire logic        singleChip,     // single chip
	input wire logic        lockWrEn,       // lock write
	input wire logic        lockoutDisable, // lock bit
	input wire logic        debugActive,    // active
	input wire logic        resetVecBlock,  // vector block
	input wire logic        regRd,          // read
	input wire logic [15:0] regAddr,        // address
	input wire logic [7:0]  regRdata,       // read data
	input wire logic        regHit,         // hit
	input wire logic        busOwn,         // bus held
	input wire logic        cpuFreeze,      // freeze
	input wire logic        accReq,         // access
	input wire logic        accMulti,       // multi
	input wire logic        busFree,        // free cycle
	input wire logic        accComplete,    // access done
	input wire logic        perClkSlower,   // forced clock
	input wire logic        perClkTick,     // peripheral tick
	input wire logic        serialTick,     // serial tick
	input wire logic        cmdValid,       // byte strobe
	input wire logic [7:0]  cmdByte,        // byte
	input wire logic        serialEnable,   // serial on
	input wire logic [1:0]  resumeKind,     // resume kind
	input wire logic [2:0]  targetReg       // target
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ==========
	// lockout and map
	a_lock_blocks_active: assert property (!lockoutDisable && !$past(lockoutDisable) |-> !debugActive)
		else $error("active while locked out");
	a_lock_holds_value: assert property (!$past(rst) && !$past(rst, 2) && !($past(lockWrEn) && !$past(specialModeN)) |-> $stable(lockoutDisable))
		else $error("lock bit changed outside a special mode write");
	a_resvec_locked: assert property ((!lockoutDisable && singleChip)[*3] |-> resetVecBlock)
		else $error("reset vector not blocked");
	a_locked_no_hit: assert property (regRd && !lockoutDisable |=> !regHit)
		else $error("register hit while locked out");
	a_status_low_zero: assert property (regRd && regAddr == `BDC_ADDR_STATUS |=> regRdata[1:0] == 2'h0)
		else $error("unused status bits not zero");
	// ==========
	// bus stealing and serial clock select
	a_freeze_owns_bus: assert property (cpuFreeze |-> busOwn)
		else $error("freeze without bus");
	a_free_cycle_take: assert property (accReq && busFree && !busOwn |-> ##[1:2] busOwn)
		else $error("free cycle not taken");
	a_release_after: assert property (accComplete && busOwn |-> ##[1:2] !busOwn)
		else $error("bus not released");
	a_single_no_freeze: assert property ($rose(busOwn) && busFree && !accMulti |-> !cpuFreeze)
		else $error("single cycle access froze processor");
	a_slow_clock_forced: assert property (perClkSlower |=> serialTick == $past(perClkTick))
		else $error("slow peripheral clock not forced");
	// ==========
	// instruction fields
	a_cmd_fields: assert property (cmdValid && serialEnable |-> ##2
		{resumeKind, targetReg} == ($past(cmdByte[7], 2) ? 5'h00 : $past(cmdByte[4:0], 2)))
		else $error("instruction fields wrong");
endmodule
bind bdc_control bdc_control_chk i_bdc_control_chk
(
	.clk_sys(clk_sys), .rst(rst), .specialModeN(specialModeN), .singleChip(singleChip), .lockWrEn(lockWrEn),
	.lockoutDisable(lockoutDisable), .debugActive(debugActive), .resetVecBlock(resetVecBlock), .regRd(regRd),
	.regAddr(regAddr), .regRdata(regRdata), .regHit(regHit), .busOwn(busOwn), .cpuFreeze(cpuFreeze),
	.accReq(accReq), .accMulti(accMulti), .busFree(busFree), .accComplete(accComplete), .cmdValid(cmdValid),
	.perClkSlower(perClkSlower), .perClkTick(perClkTick), .serialTick(serialTick),
	.cmdByte(cmdByte), .serialEnable(serialEnable), .resumeKind(resumeKind), .targetReg(targetReg)
);
`default_nettype wire

// ---- tb/tb_background_debug_control.sv ----
// tb_background_debug_control.sv: self-checking bench of the debug control block.
// assumes: design, host model and bound checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "bdc_defines.svh"
module tb_background_debug_control;
	logic        clk_sys, rst, specialModeN, singleChip, periphMode, shadowLockBit, lockWrEn, lockWrData;
	logic        altClkTick, perClkTick, hostFall, cmdValid, shiftDone, addrLoad, accReq, accMulti;
	logic        busFree, accComplete, regWr, regRd, regHit, busOwn, cpuFreeze, debugActive;
	logic        serialEnable, lockoutDisable, resetVecBlock, serialTick, sendReq, hostBusy, rdNow, perClkSlower;
	logic        ccIn, debugMapped;
	logic [7:0]  cmdByte, regWdata, regRdata, sendByte, d, ccValue;
	logic [15:0] shiftIn, regAddr;
	logic [1:0]  resumeKind;
	logic [2:0]  targetReg;
	logic [9:0]  e;
	logic [9:0]  expQ[$];
	logic [31:0] seed, r;
	int          errTotal, nTests, i, j, k;
	// ==========
	// design with short counts, debug host beside it
	bdc_control #(.IDLE_LIMIT(8), .STEAL_WAIT(4)) i_bdc_control
	(
		.clk_sys(clk_sys), .rst(rst), .specialModeN(specialModeN), .singleChip(singleChip),
		.periphMode(periphMode), .shadowLockBit(shadowLockBit), .lockWrEn(lockWrEn), .lockWrData(lockWrData),
		.altClkTick(altClkTick), .perClkTick(perClkTick), .perClkSlower(perClkSlower), .hostFall(hostFall),
		.cmdValid(cmdValid), .cmdByte(cmdByte), .shiftDone(shiftDone), .shiftIn(shiftIn), .addrLoad(addrLoad),
		.accReq(accReq), .accMulti(accMulti), .busFree(busFree), .accComplete(accComplete), .enterReq(1'b0),
		.ccIn(ccIn), .ccValue(ccValue), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regHit(regHit), .busOwn(busOwn), .cpuFreeze(cpuFreeze), .debugMapped(debugMapped),
		.debugActive(debugActive), .serialEnable(serialEnable), .lockoutDisable(lockoutDisable),
		.resetVecBlock(resetVecBlock), .serialTick(serialTick), .resumeKind(resumeKind), .targetReg(targetReg)
	);
	bdc_host_model i_bdc_host_model
	(
		.clk_sys(clk_sys), .rst(rst), .serialTick(serialTick), .sendReq(sendReq), .sendByte(sendByte),
		.busy(hostBusy), .hostFall(hostFall), .cmdValid(cmdValid), .cmdByte(cmdByte)
	);
	// ==========
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang();
		errTotal++;
		summarize();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp)
		begin
			errTotal++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		regAddr = a;
		regWdata = v;
		regWr = 1'b1;
		cyc(1);
		regWr = 1'b0;
		cyc(1);
	endtask
	// expectation: bit 9 compares data, bit 8 expected hit
	task automatic rd(input logic [15:0] a, input logic [9:0] x);
		expQ.push_back(x);
		regAddr = a;
		regRd = 1'b1;
		cyc(1);
		regRd = 1'b0;
		cyc(1);
	endtask
	task automatic cmd(input logic [7:0] b);
		int n;
		sendByte = b;
		sendReq = 1'b1;
		cyc(1);
		sendReq = 1'b0;
		for (n = 0; hostBusy !== 1'b0; n++)
		begin
			if (n == 1000)
				hang();
			cyc(1);
		end
	endtask
	// clock and random serial clock enables
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		r = rnd();
		altClkTick <= r[0];
		perClkTick <= r[1] & r[2];
	end
	// read answers compared in the cycle they stand, against the oldest expectation
	always @(posedge clk_sys)
	begin
		rdNow = regRd;
		#2;
		if (rdNow)
		begin
			e = expQ.pop_front();
			chk({7'h00, regHit}, {7'h00, e[8]});
			if (e[9])
				chk(regRdata, e[7:0]);
		end
	end
	task automatic reset(input logic sc, input logic sh);
		singleChip = sc;
		shadowLockBit = sh;
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(2);
	endtask
	// ==========
	// main sequence
	initial
	begin
		{ccIn, clk_sys, periphMode, lockWrEn, lockWrData, shiftDone, addrLoad, accReq, accMulti} = 9'h000;
		{busFree, accComplete, regWr, regRd, sendReq, perClkSlower, altClkTick, perClkTick} = 8'h00;
		{regAddr, regWdata, sendByte, shiftIn, ccValue} = 56'h0;
		{errTotal, nTests, specialModeN, rst} = 2'h3;
		seed = 32'h0000_0049;
		// lockout loaded from the shadow byte
		reset(1'b1, 1'b0);
		chk(lockoutDisable, 1'b0);
		chk(resetVecBlock, 1'b1);
		cmd(`BDC_INSTR_BACKGROUND_REQUEST);
		chk(debugActive, 1'b0);
		chk(debugMapped, 1'b0);
		rd(`BDC_ADDR_STATUS, 10'h000);
		// special single chip resets active; register bank
		reset(1'b1, 1'b1);
		chk(debugActive, 1'b1);
		chk(debugMapped, 1'b1);
		rd(`BDC_ADDR_STATUS, 10'h340);
		rd(`BDC_ADDR_INSTR, 10'h300);
		d = rnd();
		wr(`BDC_ADDR_CCSAVE, d);
		rd(`BDC_ADDR_CCSAVE, {2'h3, d});
		wr(`BDC_ADDR_STATUS, 8'hDF);
		rd(`BDC_ADDR_STATUS, 10'h3D8);
		wr(`BDC_ADDR_STATUS, 8'hC0);
		shiftIn = rnd();
		d = rnd();
		addrLoad = 1'b1;
		cyc(1);
		addrLoad = 1'b0;
		rd(`BDC_ADDR_ADDR_HI, {2'h3, shiftIn[15:8]});
		rd(`BDC_ADDR_ADDR_LO, {2'h3, shiftIn[7:0]});
		shiftIn = {d, ~d};
		shiftDone = 1'b1;
		cyc(1);
		shiftDone = 1'b0;
		rd(`BDC_ADDR_SHIFT_HI, {2'h3, d});
		rd(`BDC_ADDR_SHIFT_LO, {2'h3, ~d});
		rd(`BDC_ADDR_STATUS, 10'h3D0);
		// firmware commands and idle clear
		cmd(8'h62);
		rd(`BDC_ADDR_INSTR, 10'h362);
		cyc(60);
		rd(`BDC_ADDR_INSTR, 10'h300);
		for (i = 3; i < 8; i++)
		begin
			cmd(8'h60 | i[7:0]);
			chk({3'h0, resumeKind, targetReg}, {5'h00, i[2:0]});
		end
		cmd(8'h08);
		cmd(8'h10);
		rd(`BDC_ADDR_STATUS, 10'h3C8);
		// write permissions follow the instruction flag
		wr(`BDC_ADDR_INSTR, 8'h80);
		wr(`BDC_ADDR_STATUS, 8'h84);
		cyc(300);
		rd(`BDC_ADDR_STATUS, 10'h3C4);
		wr(`BDC_ADDR_INSTR, 8'h00);
		wr(`BDC_ADDR_STATUS, 8'h80);
		chk(debugActive, 1'b1);
		cyc(5);
		chk(debugActive, 1'b0);
		rd(`BDC_ADDR_STATUS, 10'h000);
		ccIn = 1'b1;
		ccValue = 8'(rnd());
		cmd(`BDC_INSTR_BACKGROUND_REQUEST);
		chk(debugActive, 1'b1);
		rd(`BDC_ADDR_CCSAVE, {2'h3, ccValue});
		// tagging stays idle while active; leaving active lets it take hold
		cmd(8'h18);
		chk(serialEnable, 1'b1);
		wr(`BDC_ADDR_STATUS, 8'hA0);
		cyc(20);
		chk(serialEnable, 1'b0);
		chk(debugActive, 1'b0);
		// normal mode: entry refused, accesses still run
		reset(1'b0, 1'b1);
		chk(debugActive, 1'b0);
		cmd(`BDC_INSTR_BACKGROUND_REQUEST);
		chk(debugActive, 1'b0);
		// a slower peripheral clock overrides the alternate clock
		perClkSlower = 1'b1;
		cyc(1);
		for (i = 0; i < 8; i++)
		begin
			d[0] = perClkTick;
			cyc(1);
			chk(serialTick, d[0]);
		end
		perClkSlower = 1'b0;
		for (k = 0; k < 3; k++)
		begin
			accMulti = (k == 1);
			busFree = (k != 2);
			accReq = 1'b1;
			cyc(1);
			accReq = 1'b0;
			for (j = 0; busOwn !== 1'b1; j++)
			begin
				if (j == 200)
					hang();
				cyc(1);
			end
			chk(cpuFreeze, k != 0);
			accComplete = 1'b1;
			cyc(1);
			accComplete = 1'b0;
			cyc(2);
			chk(busOwn, 1'b0);
		end
		// lock bit writes only in special mode
		for (k = 0; k < 2; k++)
		begin
			specialModeN = (k == 0);
			lockWrEn = 1'b1;
			cyc(1);
			lockWrEn = 1'b0;
			cyc(2);
			chk(lockoutDisable, k == 0);
		end
		cyc(3);
		summarize();
	end
endmodule
`default_nettype wire
